// ==== hdl/ptb_divider.sv ====
`timescale 1ns/1ps
`include "ptb_defs.svh"

module ptb_divider
	import ptb_pkg::*;
#(
	parameter int STAGES = `PTB_DIV_STAGES
) (
	input  wire logic             clk,        // Bus clock
	input  wire logic             rst_n,      // Async reset, active low
	input  wire logic             clear,      // Hold chain at zero
	input  wire logic             run,        // Chain may advance
	input  wire logic             tick,       // One reference clock edge
	input  wire ptb_rate_t        rate,       // Tap select
	output logic                  rollover    // One-cycle event pulse
);

	logic [STAGES-1:0] cnt_reg;
	logic [STAGES-1:0] tap_mask;
	logic [4:0]        tap_bit;
	logic              tap_hit;

	// Bit whose rise marks a rollover at the selected division ratio
	function automatic logic [4:0] tap_index(input ptb_rate_t r);
		unique case (r)
			3'h0: tap_index = 5'h11;
			3'h1: tap_index = 5'h10;
			3'h2: tap_index = 5'h0f;
			3'h3: tap_index = 5'h0e;
			3'h4: tap_index = 5'h05;
			3'h5: tap_index = 5'h04;
			3'h6: tap_index = 5'h03;
			3'h7: tap_index = 5'h02;
		endcase
	endfunction

	assign tap_bit  = tap_index(rate);
	assign tap_mask = STAGES'((1 << tap_bit) - 1);
	// Rising tap bit: first hit after half the period, then every full period
	assign tap_hit  = ((cnt_reg & tap_mask) == tap_mask) && !cnt_reg[tap_bit];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (clear) begin
			cnt_reg <= '0;
		end else if (run && tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rollover <= 1'b0;
		end else begin
			rollover <= !clear && run && tick && tap_hit;
		end
	end

	cnt_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		clear |=> (cnt_reg == '0) && !rollover)
		else $error("divider not held at zero while off");

	cnt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clear && !run) |=> $stable(cnt_reg) && !rollover)
		else $error("divider advanced while inactive");

endmodule // ptb_divider

// ==== hdl/ptb_top.sv ====
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ptb_defs.svh"

module ptb_top
	import ptb_pkg::*;
#(
	parameter int STAGES = `PTB_DIV_STAGES
) (
	input  wire logic        hclk,                // Bus clock, 10 MHz
	input  wire logic        hresetn,             // Async reset, active low
	input  wire logic        hsel,                // Slave select
	input  wire logic [31:0] haddr,               // Byte address
	input  wire logic [1:0]  htrans,              // Transfer type
	input  wire logic        hwrite,              // Write when high
	input  wire logic [2:0]  hsize,               // Word transfers only
	input  wire logic [31:0] hwdata,              // Write data
	input  wire logic        hready,              // Bus ready
	output logic [31:0]      hrdata,              // Read data
	output logic             hreadyout,           // Slave ready
	output logic             hresp,               // Always OKAY
	input  wire logic        osc_reference_clock, // Reference clock level
	input  wire ptb_osc_e    osc_source,          // Selected oscillator
	input  wire logic        cpu_wait_mode,       // CPU in wait
	input  wire logic        cpu_stop_mode,       // CPU in stop
	output logic             period_irq,          // Interrupt request
	output logic             stop_wakeup          // Wake pulse from stop
);

	ptb_bus_e    state_reg;
	logic [7:0]  addr_reg;
	ptb_rate_t   rate_select;
	logic        period_irq_enable;
	logic        timebase_on;
	logic        period_pending_flag;
	logic        stop_internal_osc_disable;
	logic        stop_rc_osc_keep;
	logic        stop_crystal_osc_keep;
	logic        osc_prev_reg;
	logic        osc_tick;
	logic        osc_kept;
	logic        tb_run;
	logic        tb_event;
	logic        locked;
	logic        addr_take;
	logic        wr_ctrl;
	logic        wr_cfg;
	logic        ack_write;

	// Stop-mode keep-alive of whichever oscillator drives the reference
	function automatic logic osc_keep(input ptb_osc_e src, input logic int_dis,
		input logic rc_keep, input logic xtal_keep);
		unique case (src)
			PTB_OSC_INTERNAL: osc_keep = !int_dis;
			PTB_OSC_RC:       osc_keep = rc_keep;
			default:          osc_keep = xtal_keep;
		endcase
	endfunction

	assign hresp     = 1'b0;
	assign addr_take = hsel && htrans[1] && hready;
	assign locked    = cpu_wait_mode || cpu_stop_mode;
	assign wr_ctrl   = (state_reg == PTB_WRITE) && (addr_reg == `PTB_CTRL_OFS) && !locked;
	assign wr_cfg    = (state_reg == PTB_WRITE) && (addr_reg == `PTB_CFG_OFS) && !locked;
	assign ack_write = wr_ctrl && hwdata[`PTB_ACK_BIT];
	assign osc_tick  = osc_reference_clock && !osc_prev_reg;
	assign osc_kept  = osc_keep(osc_source, stop_internal_osc_disable,
		stop_rc_osc_keep, stop_crystal_osc_keep);
	assign tb_run    = !cpu_stop_mode || osc_kept;

	// Bus data phase tracking; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= PTB_IDLE;
			addr_reg  <= 8'h00;
			hreadyout <= 1'b1;
		end else begin
			if (addr_take) begin
				state_reg <= hwrite ? PTB_WRITE : PTB_READ;
				addr_reg  <= {haddr[7:2], 2'b00};
			end else begin
				state_reg <= PTB_IDLE;
			end
			hreadyout <= !(addr_take && !hwrite);
		end
	end

	// Read data; unmapped or locked-out reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (state_reg == PTB_READ) begin
			hrdata <= 32'h0000_0000;
			if (!locked && addr_reg == `PTB_CTRL_OFS) begin
				hrdata[`PTB_FLAG_BIT]                 <= period_pending_flag;
				hrdata[`PTB_RATE_MSB:`PTB_RATE_LSB]   <= rate_select;
				hrdata[`PTB_IEN_BIT]                  <= period_irq_enable;
				hrdata[`PTB_ON_BIT]                   <= timebase_on;
			end else if (!locked && addr_reg == `PTB_CFG_OFS) begin
				hrdata[`PTB_INT_DIS_BIT]              <= stop_internal_osc_disable;
				hrdata[`PTB_RC_KEEP_BIT]              <= stop_rc_osc_keep;
				hrdata[`PTB_XTAL_KEEP_BIT]            <= stop_crystal_osc_keep;
			end
		end
	end

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_select       <= `PTB_RATE_RST;
			period_irq_enable <= 1'b0;
			timebase_on       <= 1'b0;
		end else if (wr_ctrl) begin
			rate_select       <= hwdata[`PTB_RATE_MSB:`PTB_RATE_LSB];
			period_irq_enable <= hwdata[`PTB_IEN_BIT];
			timebase_on       <= hwdata[`PTB_ON_BIT];
		end
	end

	// Stop-mode oscillator configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{stop_crystal_osc_keep, stop_rc_osc_keep, stop_internal_osc_disable} <= `PTB_CFG_RST;
		end else if (wr_cfg) begin
			stop_internal_osc_disable <= hwdata[`PTB_INT_DIS_BIT];
			stop_rc_osc_keep          <= hwdata[`PTB_RC_KEEP_BIT];
			stop_crystal_osc_keep     <= hwdata[`PTB_XTAL_KEEP_BIT];
		end
	end

	// Pending flag: a rollover in the clearing cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_pending_flag <= 1'b0;
		end else begin
			period_pending_flag <= tb_event || (period_pending_flag && !ack_write);
		end
	end

	// Reference clock edge detect; clock is at most hclk/2
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_prev_reg <= 1'b0;
		end else begin
			osc_prev_reg <= osc_reference_clock;
		end
	end

	// Interrupt request and stop wake-up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_irq  <= 1'b0;
			stop_wakeup <= 1'b0;
		end else begin
			period_irq  <= period_pending_flag && period_irq_enable;
			stop_wakeup <= tb_event && cpu_stop_mode;
		end
	end

	ptb_divider #(
		.STAGES   (STAGES)
	) u_divider (
		.clk      (hclk),
		.rst_n    (hresetn),
		.clear    (!timebase_on),
		.run      (tb_run),
		.tick     (osc_tick),
		.rate     (rate_select),
		.rollover (tb_event)
	);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	flag_set_a: assert property (tb_event |=> period_pending_flag)
		else $error("rollover did not set pending flag");

	irq_raise_a: assert property (
		(period_pending_flag && period_irq_enable) |=> period_irq)
		else $error("enabled pending flag gave no request");

	irq_gate_a: assert property (!period_irq_enable |=> !period_irq)
		else $error("request raised while disabled");

	ack_clear_a: assert property (
		(ack_write && !tb_event) |=> !period_pending_flag ##1 !period_irq)
		else $error("acknowledge did not clear pending flag");

	ack_zero_a: assert property (
		(state_reg == PTB_READ) |=> !hrdata[`PTB_ACK_BIT] && hreadyout)
		else $error("acknowledge bit read as one");

	lock_write_a: assert property (
		((state_reg == PTB_WRITE) && locked) |=>
			$stable(timebase_on) && $stable(period_irq_enable) && $stable(rate_select))
		else $error("control written during low-power mode");

	lock_read_a: assert property (
		((state_reg == PTB_READ) && locked) |=> (hrdata == 32'h0000_0000))
		else $error("control readable during low-power mode");

	stop_wake_a: assert property (
		(tb_event && cpu_stop_mode) |=> stop_wakeup ##1 !stop_wakeup)
		else $error("no single wake pulse in stop");

	stop_idle_a: assert property (
		(cpu_stop_mode && !osc_kept) |=> !tb_event)
		else $error("timebase active in stop without oscillator");

	read_wait_a: assert property (
		(addr_take && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule // ptb_top

// ==== inc/ptb_defs.svh ====
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH

// Word addresses (byte offsets) of the registers
`define PTB_CTRL_OFS     8'h00
`define PTB_CFG_OFS      8'h04

// Control register fields
`define PTB_FLAG_BIT     7
`define PTB_RATE_MSB     6
`define PTB_RATE_LSB     4
`define PTB_ACK_BIT      3
`define PTB_IEN_BIT      2
`define PTB_ON_BIT       1

// Stop-mode oscillator configuration fields
`define PTB_INT_DIS_BIT  0
`define PTB_RC_KEEP_BIT  1
`define PTB_XTAL_KEEP_BIT 2

// Reset values
`define PTB_RATE_RST     3'h0
`define PTB_CFG_RST      3'h0

// Divider chain length
`define PTB_DIV_STAGES   18

`endif

// ==== inc/ptb_pkg.sv ====
package ptb_pkg;

	// Data phase of the current bus transfer
	typedef enum logic [2:0] {
		PTB_IDLE  = 3'b001,
		PTB_WRITE = 3'b010,
		PTB_READ  = 3'b100
	} ptb_bus_e;

	// Oscillator feeding the reference clock
	typedef enum logic [1:0] {
		PTB_OSC_INTERNAL = 2'h0,
		PTB_OSC_RC       = 2'h1,
		PTB_OSC_CRYSTAL  = 2'h2
	} ptb_osc_e;

	typedef logic [2:0] ptb_rate_t;

endpackage

// ==== tb/ptb_cpu_model.sv ====
`timescale 1ns/1ps
module ptb_cpu_model (
	input  wire logic        hclk,   // Bus clock
	input  wire logic        hready, // Bus ready
	input  wire logic [31:0] hrdata, // Read data
	output logic             hsel,   // Slave select
	output logic [31:0]      haddr,  // Byte address
	output logic [1:0]       htrans, // Transfer type
	output logic             hwrite, // Write when high
	output logic [2:0]       hsize,  // Word size
	output logic [31:0]      hwdata, // Write data
	output logic             osc_ref // Reference clock
);
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata, osc_ref} = '0;
		hsize = 3'h2;
	end
	// Reference runs free, one rising edge every two bus clocks
	always @(posedge hclk) begin
		osc_ref <= ~osc_ref;
	end
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		// Released data bus shows a changing pattern, not the last value
		hwdata <= ~wd;
	endtask
endmodule // ptb_cpu_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "ptb_defs.svh"
module tb_top;
	import ptb_pkg::*;
	typedef struct {logic [2:0] code; int ratio;} ptb_row_s;
	logic        hclk, hresetn, hready, osc, wait_m, stop_m, irq, wake, hsel, hwrite, hresp;
	logic        irq_d = 1'b0;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	ptb_osc_e    src;
	int          bad_count, n_tests, cyc, n_rise, n_wake, t_last, t_prev, t0, k;
	ptb_row_s    rows [4] = '{'{3'h4, 64}, '{3'h5, 32}, '{3'h6, 16}, '{3'h7, 8}};
	ptb_osc_e    srcs [4] = '{PTB_OSC_INTERNAL, PTB_OSC_INTERNAL, PTB_OSC_RC, PTB_OSC_CRYSTAL};
	logic [2:0]  cfgs [4] = '{3'h0, 3'h1, 3'h2, 3'h2};
	logic        runs [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	ptb_top i_ptb_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout(hready), .hresp, .osc_reference_clock(osc),
		.osc_source(src), .cpu_wait_mode(wait_m), .cpu_stop_mode(stop_m),
		.period_irq(irq), .stop_wakeup(wake));
	ptb_cpu_model i_ptb_cpu_model (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .osc_ref(osc));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// Time stamps of request rises and count of wake pulses
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		irq_d <= irq;
		if (irq === 1'b1 && irq_d !== 1'b1) begin
			n_rise <= n_rise + 1;
			t_prev <= t_last;
			t_last <= cyc;
		end
		if (wake === 1'b1) n_wake <= n_wake + 1;
	end

	function automatic logic [31:0] ctl(logic [2:0] r, logic ack, logic ien);
		return {25'h0, r, ack, ien, 2'b10};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_ptb_cpu_model.xfer(1'b1, a, d, rd);
	endtask
	task automatic rr(input logic [7:0] a);
		i_ptb_cpu_model.xfer(1'b0, a, 32'h0, rd);
	endtask
	task automatic wait_rise;
		int k0;
		k0 = n_rise;
		repeat (400) begin
			if (n_rise != k0) break;
			@(posedge hclk);
		end
	endtask
	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge hclk);
		bad_count++;
		end_of_test;
	end

	initial begin
		hresetn = 1'b0;
		src = PTB_OSC_INTERNAL;
		wait_m = 1'b0;
		stop_m = 1'b0;
		do_reset;
		rr(`PTB_CTRL_OFS); check(rd, 32'h0);
		rr(`PTB_CFG_OFS); check(rd, 32'h0);
		rr(8'h08); check(rd, 32'h0);
		// Slow rates cannot run to an event here; their codes must still stick
		for (int r = 0; r < 4; r++) begin
			wr(`PTB_CTRL_OFS, 32'(r) << `PTB_RATE_LSB);
			rr(`PTB_CTRL_OFS); check(rd, 32'(r) << `PTB_RATE_LSB);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			wr(`PTB_CTRL_OFS, 32'h0);
			// Flag left from the previous row must not raise the request early
			wr(`PTB_CTRL_OFS, 32'h1 << `PTB_ACK_BIT);
			wr(`PTB_CTRL_OFS, ctl(rows[i].code, 1'b0, 1'b1));
			t0 = cyc;
			wait_rise;
			check(32'(t_last - t0 >= rows[i].ratio - 1 && t_last - t0 <= rows[i].ratio + 6), 32'h1);
			wr(`PTB_CTRL_OFS, ctl(rows[i].code, 1'b1, 1'b1));
			rr(`PTB_CTRL_OFS); check(rd, ctl(rows[i].code, 1'b0, 1'b1));
			wait_rise;
			check(32'(t_last - t_prev), 32'(2 * rows[i].ratio));
			$display("test rate %0d done", rows[i].code);
		end
		wr(`PTB_CTRL_OFS, ctl(3'h7, 1'b0, 1'b1));
		rr(`PTB_CTRL_OFS); check(rd, 32'h80 | ctl(3'h7, 1'b0, 1'b1));
		check({31'h0, irq}, 32'h1);
		wr(`PTB_CTRL_OFS, ctl(3'h7, 1'b0, 1'b0));
		repeat (2) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		// Events keep coming with the flag still set; request stays low
		repeat (20) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		$display("test ack and enable done");
		wr(`PTB_CTRL_OFS, ctl(3'h7, 1'b1, 1'b1));
		wait_m <= 1'b1;
		k = n_rise;
		rr(`PTB_CTRL_OFS); check(rd, 32'h0);
		check({31'h0, hresp}, 32'h0);
		wr(`PTB_CTRL_OFS, 32'h0);
		repeat (24) @(posedge hclk);
		check(32'(n_rise != k), 32'h1);
		wait_m <= 1'b0;
		rr(`PTB_CTRL_OFS); check(rd & 32'h7f, ctl(3'h7, 1'b0, 1'b1));
		$display("test wait done");
		for (int j = 0; j < 4; j++) begin
			wr(`PTB_CFG_OFS, {29'h0, cfgs[j]});
			src <= srcs[j];
			stop_m <= 1'b1;
			rr(`PTB_CTRL_OFS); check(rd, 32'h0);
			// Count only after a rollover already in flight has been seen
			k = n_wake;
			repeat (40) @(posedge hclk);
			check(32'(n_wake != k), {31'h0, runs[j]});
			stop_m <= 1'b0;
		end
		$display("test stop done");
		do_reset;
		@(posedge hclk);
		check({31'h0, irq}, 32'h0);
		rr(`PTB_CTRL_OFS); check(rd, 32'h0);
		rr(`PTB_CFG_OFS); check(rd, 32'h0);
		$display("test mid-run reset done");
		end_of_test;
	end
endmodule // tb_top
